// ---- clock_router_pkg.sv ----
// constants, field layouts and types shared by the clock router and its
// configuration store; assumes a single 125 MHz system clock.
package clock_router_pkg;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_MHZ = 125;               // system clock, 8 ns period
    localparam int LOCK_TYP_US = 1000;          // typical lock time, 1.0 ms
    localparam int LOCK_MAX_US = 3000;          // longest lock time, 3 ms
    localparam int LOCK_TYP_CYCLES = LOCK_TYP_US * CLK_MHZ;
    localparam int LOCK_MAX_CYCLES = LOCK_MAX_US * CLK_MHZ;
    localparam int LOCK_CNT_W = 19;             // holds LOCK_MAX_CYCLES

    // -------------------------------------------------------------------
    // crystal load capacitance, in femtofarads
    // -------------------------------------------------------------------
    localparam int CAP_MIN_FF = 6000;           // 6 pF at code zero
    localparam int CAP_STEP_FF = 375;           // 0.375 pF per code step
    localparam int CAP_MAX_FF = 30000;          // 30 pF range end
    localparam int BYPASS_MAX_MHZ = 166;        // driven reference limit

    // -------------------------------------------------------------------
    // register map: word index, byte offset is four times the index
    // -------------------------------------------------------------------
    localparam int NV_WORDS = 8;
    localparam logic [3:0] IDX_SYN1_SET0 = 4'h0;
    localparam logic [3:0] IDX_SYN1_SET1 = 4'h1;
    localparam logic [3:0] IDX_SYN2 = 4'h2;
    localparam logic [3:0] IDX_SYN3 = 4'h3;
    localparam logic [3:0] IDX_OUT_A = 4'h4;
    localparam logic [3:0] IDX_OUT_B = 4'h5;
    localparam logic [3:0] IDX_OUT_C = 4'h6;
    localparam logic [3:0] IDX_MISC = 4'h7;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam logic [3:0] IDX_CTRL = 4'h9;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int Q_LSB = 0;                   // eight-bit predivider
    localparam int P_LSB = 8;                   // eleven-bit multiplier
    localparam int DIV0_LSB = 0;                // post divider, select low
    localparam int DIV1_LSB = 8;                // post divider, select high
    localparam int SRC_LSB = 16;                // crosspoint source
    localparam int INV_BIT = 18;                // inverted phase
    localparam int FUNC_LSB = 0;                // pin function
    localparam int SUSP_FS_BIT = 2;             // suspend alongside select
    localparam int SUSP_SYN_LSB = 4;            // suspended synthesizers
    localparam int SUSP_OUT_LSB = 8;            // suspended outputs
    localparam int CAP_LSB = 16;                // load capacitance code
    localparam int DRV_LSB = 24;                // oscillator drive strength
    localparam int BYP_BIT = 26;                // load capacitor bypass
    localparam int CTRL_RELOAD_BIT = 0;         // reload from store

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        PIN_FREQ_SELECT,
        PIN_SUSPEND,
        PIN_OUTPUT_ENABLE,
        PIN_SHUTDOWN
    } pin_func_t;

    typedef enum logic [1:0] {
        SRC_REF,
        SRC_SYNTH_ONE,
        SRC_SYNTH_TWO,
        SRC_SYNTH_THREE
    } src_t;

    // -------------------------------------------------------------------
    // content of the store before anything is programmed
    // -------------------------------------------------------------------
    localparam logic [NV_WORDS-1:0][31:0] NV_DEFAULT = {
        32'h0020_0000,  // misc: select pin, cap code 0x20
        32'h0000_0004,  // out c: reference / 4
        32'h0000_0402,  // out b: reference / 2 or / 4
        32'h0000_0201,  // out a: reference / 1 or / 2
        32'h0000_0102,  // synth three: 1/2
        32'h0000_0102,  // synth two: 1/2
        32'h0000_0104,  // synth one set 1: 1/4
        32'h0000_0102   // synth one set 0: 1/2
    };

endpackage : clock_router_pkg

// ---- cfg_store_if.sv ----
// bundle between the router and its configuration store;
// assumes the store answers reads one clock after the address.
`timescale 1ns/100ps
interface cfg_store_if;
    logic wr_en;            // write strobe
    logic [3:0] wr_be;      // byte enables of the write
    logic [2:0] wr_addr;    // word written
    logic [31:0] wr_data;   // data written
    logic [2:0] rd_addr;    // word read
    logic [31:0] rd_data;   // registered read data

    modport store (input wr_en, input wr_be, input wr_addr, input wr_data, input rd_addr, output rd_data);
    modport user (output wr_en, output wr_be, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface : cfg_store_if

// ---- cfg_store.sv ----
// nonvolatile configuration store with byte-enabled writes;
// assumes the read address is held by the user, data one clock later.
`timescale 1ns/100ps
module cfg_store #(
    parameter int WORDS = clock_router_pkg::NV_WORDS
) (
    // clock
    input wire logic clk,
    // access
    cfg_store_if.store port
);

    typedef struct packed {
        logic [WORDS-1:0][31:0] mem;  // stored words
        logic [31:0] rdata;           // read register
    } state_t;

    // contents survive reset: no reset term, only the shipped defaults
    state_t state_q = '{mem: clock_router_pkg::NV_DEFAULT, rdata: 32'h0000_0000};
    state_t state_d;

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // read first, so a same-cycle write shows next access
        state_d.rdata = state_q.mem[port.rd_addr];
        if (port.wr_en) begin
            for (int b = 0; b < 4; b++) begin
                if (port.wr_be[b]) begin
                    state_d.mem[port.wr_addr][8*b +: 8] = port.wr_data[8*b +: 8];
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    assign port.rd_data = state_q.rdata;

endmodule : cfg_store

// ---- three_synth_clock_router.sv ----
// three-synthesizer clock router: store load, synthesizers, crosspoint,
// post dividers, pin functions and crystal settings, Avalon-MM slave.
// assumes all inputs synchronous to clk; clocks are modelled as edges of clk.
//
// How it works
// - synthesizer rate is reference times multiplier over predivider, at most reference
// - control pin serves one of four functions
// - select level picks synth one and divider set
// - divider changes land only at period boundaries
// - low pin suspends configured synthesizers and outputs
// - output enable low tri-states all three outputs
// - shutdown tri-states outputs, stops oscillator, reference, synthesizers and dividers; bus keeps answering
// - leaving shutdown forces a new lock wait
// - six-bit load capacitance code, 0.375 pF steps
// - oscillator drive strength comes from configuration
// - driven reference bypasses caps, feedback left floating
// - crosspoint routes four sources through seven-bit dividers
// - outputs a and b pick divider by select
// - output c has one divider, select ignored
// - suspended synthesizer stops; suspended output only floats
// - inverted phase selectable per output
// - lock within the lock-time count after start
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/100ps
module three_synth_clock_router #(
    parameter int LOCK_CYCLES = clock_router_pkg::LOCK_TYP_CYCLES  // lock wait per synthesizer
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // multipurpose control pin
    input wire logic ctrl_pin,
    // clock outputs with their drive enables
    output logic output_clock_a,
    output logic output_clock_a_oe,
    output logic output_clock_b,
    output logic output_clock_b_oe,
    output logic output_clock_c,
    output logic output_clock_c_oe,
    // oscillator controls
    output logic osc_enable,
    output logic osc_feedback_oe,
    output logic [5:0] cap_load_code,
    output logic cap_bypass,
    output logic [1:0] osc_drive
);

    typedef enum logic {ST_LOAD, ST_RUN} st_t;

    typedef struct packed {
        st_t st;                                    // load or run
        logic [2:0] ld_idx;                         // word being read
        logic ld_cap;                               // data due this cycle
        logic [2:0] cap_idx;                        // word that data belongs to
        logic [7:0][31:0] cfg;                      // live configuration
        logic [1:0] phase;                          // bus wait phase
        logic [31:0] rdata;                         // bus read data
        logic [2:0][7:0] acc;                       // rate accumulators
        logic [2:0][clock_router_pkg::LOCK_CNT_W-1:0] lock_cnt;  // lock timers
        logic [2:0] locked;                         // synthesizer locked
        logic [2:0][6:0] dcnt;                      // divider counters
        logic [2:0][6:0] dcur;                      // divider in use
        logic [2:0] lvl;                            // divider output level
        logic [2:0] oclk;                           // output clock levels
        logic [2:0] oe;                             // output drive enables
    } state_t;

    state_t state_q;
    state_t state_d;
    cfg_store_if store_bus ();

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    // a zero divider or predivider behaves as one
    function automatic logic [6:0] div_of(input logic [6:0] v);
        return (v == 7'h00) ? 7'h01 : v;
    endfunction : div_of

    function automatic logic [7:0] q_of(input logic [31:0] w);
        return (w[clock_router_pkg::Q_LSB +: 8] == 8'h00) ? 8'h01 : w[clock_router_pkg::Q_LSB +: 8];
    endfunction : q_of

    localparam logic [clock_router_pkg::LOCK_CNT_W-1:0] LOCK_END = clock_router_pkg::LOCK_CNT_W'(LOCK_CYCLES);

    // -------------------------------------------------------------------
    // configuration store
    // -------------------------------------------------------------------
    cfg_store #(
        .WORDS(clock_router_pkg::NV_WORDS)
    ) u_store (
        .clk(clk),
        .port(store_bus.store)
    );

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    logic [31:0] misc;          // misc word in use
    logic [1:0] func;           // pin function
    logic shut;                 // shutdown in force
    logic oe_off;               // output enable low
    logic susp;                 // suspend in force
    logic fs;                   // frequency select level
    logic run;                  // configuration loaded
    logic req;                  // bus request present
    logic [3:0] idx;            // bus word index
    logic [3:0] tick;           // source edges: ref, synth one..three
    logic [31:0] sw;            // synthesizer word in use
    logic [31:0] ow;            // output word in use
    logic [11:0] sum;           // accumulator sum
    logic [6:0] ndiv;           // divider wanted now
    logic [1:0] src;            // selected source

    always_comb begin
        state_d = state_q;
        run = (state_q.st == ST_RUN);
        misc = state_q.cfg[clock_router_pkg::IDX_MISC[2:0]];
        func = misc[clock_router_pkg::FUNC_LSB +: 2];
        // pin decoding, one function at a time
        shut = run && !ctrl_pin && (func == clock_router_pkg::PIN_SHUTDOWN);
        oe_off = !ctrl_pin && (func == clock_router_pkg::PIN_OUTPUT_ENABLE);
        susp = !ctrl_pin && ((func == clock_router_pkg::PIN_SUSPEND) ||
            ((func == clock_router_pkg::PIN_FREQ_SELECT) && misc[clock_router_pkg::SUSP_FS_BIT]));
        fs = ctrl_pin && (func == clock_router_pkg::PIN_FREQ_SELECT);
        req = (read || write) && run;
        idx = address[5:2];
        tick = 4'h0;
        sw = 32'h0000_0000;
        ow = 32'h0000_0000;
        sum = 12'h000;
        ndiv = 7'h01;
        src = 2'h0;

        // store load after reset or reload; bus stalls meanwhile
        state_d.ld_cap = 1'b0;
        if (!run) begin
            state_d.ld_cap = !(state_q.ld_cap && (state_q.cap_idx == 3'h7));
            state_d.cap_idx = state_q.ld_idx;
            state_d.ld_idx = state_q.ld_idx + 3'h1;
            if (state_q.ld_cap) begin
                state_d.cfg[state_q.cap_idx] = store_bus.rd_data;
                if (state_q.cap_idx == 3'h7) begin
                    state_d.st = ST_RUN;
                    state_d.ld_idx = 3'h0;
                end
            end
        end

        // bus: two wait cycles, then answer on the third
        state_d.phase = (req && (state_q.phase != 2'h2)) ? state_q.phase + 2'h1 : 2'h0;
        // only reads load the read register; writes leave the last read data standing
        if (read && run && (state_q.phase == 2'h1)) begin
            if (idx < 4'(clock_router_pkg::NV_WORDS)) begin
                state_d.rdata = store_bus.rd_data;
            end else if (idx == clock_router_pkg::IDX_STATUS) begin
                state_d.rdata = {24'h00_0000, state_q.oe, ctrl_pin, 1'b1, state_q.locked};
            end else begin
                state_d.rdata = 32'h0000_0000;
            end
        end
        if (write && run && (state_q.phase == 2'h2) && (idx == clock_router_pkg::IDX_CTRL) &&
            byteenable[0] && writedata[clock_router_pkg::CTRL_RELOAD_BIT]) begin
            state_d.st = ST_LOAD;
        end

        // reference keeps running except in shutdown or during the store load
        tick[0] = run && !shut;

        // synthesizers
        for (int i = 0; i < 3; i++) begin
            if (i == 0) begin
                sw = fs ? state_q.cfg[clock_router_pkg::IDX_SYN1_SET1[2:0]]
                    : state_q.cfg[clock_router_pkg::IDX_SYN1_SET0[2:0]];
            end else begin
                sw = state_q.cfg[i + 1];
            end
            if (!run || shut || (susp && misc[clock_router_pkg::SUSP_SYN_LSB + i])) begin
                // stopped: all logic cleared, lock starts over
                state_d.acc[i] = 8'h00;
                state_d.lock_cnt[i] = '0;
                state_d.locked[i] = 1'b0;
            end else begin
                if (state_q.lock_cnt[i] >= LOCK_END - 1'b1) begin
                    state_d.locked[i] = 1'b1;
                end else begin
                    state_d.lock_cnt[i] = state_q.lock_cnt[i] + 1'b1;
                end
                // edge rate is reference * p / q, capped at reference
                sum = 12'(state_q.acc[i]) + 12'(sw[clock_router_pkg::P_LSB +: 11]);
                if (sw[clock_router_pkg::P_LSB +: 11] >= 11'(q_of(sw))) begin
                    state_d.acc[i] = 8'h00;
                    tick[i + 1] = state_q.locked[i];
                end else if (sum >= 12'(q_of(sw))) begin
                    state_d.acc[i] = 8'(sum - 12'(q_of(sw)));
                    tick[i + 1] = state_q.locked[i];
                end else begin
                    state_d.acc[i] = 8'(sum);
                end
            end
        end

        // crosspoint and post dividers
        for (int j = 0; j < 3; j++) begin
            ow = state_q.cfg[clock_router_pkg::IDX_OUT_A[2:0] + 3'(j)];
            src = ow[clock_router_pkg::SRC_LSB +: 2];
            if (j == 2) begin
                ndiv = div_of(ow[clock_router_pkg::DIV0_LSB +: 7]);
            end else begin
                ndiv = div_of(fs ? ow[clock_router_pkg::DIV1_LSB +: 7] : ow[clock_router_pkg::DIV0_LSB +: 7]);
            end
            if (!run || shut) begin
                // counters halted and cleared
                state_d.dcnt[j] = 7'h00;
                state_d.lvl[j] = 1'b0;
                state_d.dcur[j] = ndiv;
            end else if (tick[src]) begin
                // toggle every n source edges: period of 2n source periods
                if (state_q.dcnt[j] + 7'h01 >= state_q.dcur[j]) begin
                    state_d.dcnt[j] = 7'h00;
                    state_d.lvl[j] = !state_q.lvl[j];
                    if (!state_q.lvl[j]) begin
                        // level about to rise: new divider only at the start of a period
                        state_d.dcur[j] = ndiv;
                    end
                end else begin
                    state_d.dcnt[j] = state_q.dcnt[j] + 7'h01;
                end
            end
            state_d.oclk[j] = state_d.lvl[j] ^ ow[clock_router_pkg::INV_BIT];
            // suspended outputs only float; their counters go on
            state_d.oe[j] = run && !shut && !oe_off &&
                !(susp && misc[clock_router_pkg::SUSP_OUT_LSB + j]);
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // -------------------------------------------------------------------
    // store access: load walk has the read port, else the bus
    // -------------------------------------------------------------------
    assign store_bus.rd_addr = (state_q.st == ST_RUN) ? address[4:2] : state_q.ld_idx;
    assign store_bus.wr_en = write && (state_q.st == ST_RUN) && (state_q.phase == 2'h2) &&
        (address[5:2] < 4'(clock_router_pkg::NV_WORDS));
    assign store_bus.wr_be = byteenable;
    assign store_bus.wr_addr = address[4:2];
    assign store_bus.wr_data = writedata;

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign waitrequest = (read || write) && !((state_q.st == ST_RUN) && (state_q.phase == 2'h2));
    assign readdata = state_q.rdata;
    assign output_clock_a = state_q.oclk[0];
    assign output_clock_b = state_q.oclk[1];
    assign output_clock_c = state_q.oclk[2];
    assign output_clock_a_oe = state_q.oe[0];
    assign output_clock_b_oe = state_q.oe[1];
    assign output_clock_c_oe = state_q.oe[2];
    // oscillator off in shutdown; settings straight from the live word
    assign osc_enable = (state_q.st == ST_RUN) && !shut;
    assign cap_bypass = misc[clock_router_pkg::BYP_BIT];
    // a driven reference gets no load caps and no feedback drive
    assign cap_load_code = cap_bypass ? 6'h00 : misc[clock_router_pkg::CAP_LSB +: 6];
    assign osc_feedback_oe = osc_enable && !cap_bypass;
    assign osc_drive = misc[clock_router_pkg::DRV_LSB +: 2];

endmodule : three_synth_clock_router

// ---- clock_sink.sv ----
// downstream clock consumer: measures the period of one routed clock.
// assumes the clock is sampled on the system clock edges.
`timescale 1ns/100ps
module clock_sink (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // observed clock pin
    input wire logic clk_in,
    input wire logic oe,
    // measured period in system cycles
    output int period
);
    // -------------------------------------------------------------------
    // period counter
    // -------------------------------------------------------------------
    int cnt;        // cycles since last rising edge
    logic prev;     // last sampled pin level
    // a floating pin has no period, so the count restarts whenever oe drops
    always @(posedge clk) begin
        prev <= clk_in;
        if (reset || !oe) begin
            cnt <= 0;
            period <= 0;
        end else if (clk_in && !prev) begin
            period <= cnt + 1;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : clock_sink

// ---- three_synth_clock_router_assertions.sv ----
// port checker for the clock router; bound to every instance.
// assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module clock_router_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // outputs
    input wire logic output_clock_a_oe,
    input wire logic output_clock_b_oe,
    input wire logic output_clock_c_oe,
    input wire logic osc_enable,
    input wire logic osc_feedback_oe,
    input wire logic [5:0] cap_load_code,
    input wire logic cap_bypass
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // any enable means some output is driven
    wire logic any_oe = output_clock_a_oe | output_clock_b_oe | output_clock_c_oe;
    a_idle_no_wait: assert property (!(read || write) |-> !waitrequest) else $error("stall without request");
    a_first_two_stall: assert property ($rose(read) |-> waitrequest [*2]) else $error("answer too early");
    a_answer_bound: assert property ($rose(read || write) |-> ##[0:15] !waitrequest) else $error("no answer");
    a_rdata_hold: assert property (!read |=> $stable(readdata)) else $error("read data moved");
    a_bypass_feedback: assert property (cap_bypass |-> !osc_feedback_oe) else $error("feedback driven");
    a_bypass_cap_zero: assert property (cap_bypass |-> cap_load_code == 6'h00) else $error("caps in bypass");
    a_osc_off_fb: assert property (!osc_enable |-> !osc_feedback_oe) else $error("feedback without osc");
    a_osc_off_hiz: assert property (!osc_enable && $past(!osc_enable) |-> !any_oe) else $error("driven while off");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !any_oe && readdata == 32'h0) else $error("reset");
    c_read_done: cover property (read && !waitrequest);
    c_write_done: cover property (write && !waitrequest);
    c_osc_off: cover property ($fell(osc_enable));
endmodule : clock_router_checker
bind three_synth_clock_router clock_router_checker u_clock_router_checker (.clk(clk), .reset(reset), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest), .output_clock_a_oe(output_clock_a_oe),
    .output_clock_b_oe(output_clock_b_oe), .output_clock_c_oe(output_clock_c_oe), .osc_enable(osc_enable),
    .osc_feedback_oe(osc_feedback_oe), .cap_load_code(cap_load_code), .cap_bypass(cap_bypass));

// ---- three_synth_clock_router_bench.sv ----
// self-checking bench: avalon tasks, pin functions, divider periods.
// assumes store defaults of the package and a short lock count.
`timescale 1ns/100ps
`define check_eq(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: %0h vs %0h", $time, (g), (e)); end end
module three_synth_clock_router_bench;
    logic clk = 0, reset = 1, read = 0, write = 0, ctrl_pin = 0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata;
    logic [3:0] byteenable = 4'hf;
    logic waitrequest, ca, cb, cc, ea, eb, ec, osc_en, fb_oe, byp;
    logic [5:0] cap;
    logic [1:0] drv;
    int per_a, per_b, per_c, err_count = 0, samples_checked = 0;
    always #4 clk = ~clk;
    // short lock count keeps relock waits brief
    three_synth_clock_router #(.LOCK_CYCLES(8)) u_three_synth_clock_router (.clk(clk), .reset(reset),
        .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .ctrl_pin(ctrl_pin), .output_clock_a(ca),
        .output_clock_a_oe(ea), .output_clock_b(cb), .output_clock_b_oe(eb), .output_clock_c(cc),
        .output_clock_c_oe(ec), .osc_enable(osc_en), .osc_feedback_oe(fb_oe), .cap_load_code(cap),
        .cap_bypass(byp), .osc_drive(drv));
    clock_sink u_sink_a (.clk(clk), .reset(reset), .clk_in(ca), .oe(ea), .period(per_a));
    clock_sink u_sink_b (.clk(clk), .reset(reset), .clk_in(cb), .oe(eb), .period(per_b));
    clock_sink u_sink_c (.clk(clk), .reset(reset), .clk_in(cc), .oe(ec), .period(per_c));
    // one bus cycle; held until waitrequest is sampled low
    // no cycle limit of its own: only the watchdog ends a hung wait
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        if (!wr) `check_eq(readdata, exp)
        read <= 0;
        write <= 0;
    endtask : bus
    // new misc word, reload, settle through load and lock
    task automatic set_misc(input logic [31:0] d);
        bus(1, 6'h1c, d, 0);
        bus(1, 6'h24, 32'h1, 0);
        repeat (40) @(posedge clk);
    endtask : set_misc
    task automatic end_sim;
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 0;
        bus(0, 6'h00, 0, 32'h0000_0102);
        bus(0, 6'h1c, 0, 32'h0020_0000);
        bus(0, 6'h28, 0, 32'h0);
        `check_eq(cap, 6'h20)
        repeat (60) @(posedge clk);
        `check_eq(per_a, 2)
        `check_eq(per_b, 4)
        `check_eq(per_c, 8)
        ctrl_pin <= 1;
        repeat (40) @(posedge clk);
        `check_eq(per_a, 4)
        `check_eq(per_b, 8)
        `check_eq(per_c, 8)
        set_misc(32'h0020_0002);
        ctrl_pin <= 0;
        repeat (4) @(posedge clk);
        `check_eq({ea, eb, ec}, 3'b000)
        ctrl_pin <= 1;
        set_misc(32'h0020_0401);
        ctrl_pin <= 0;
        repeat (4) @(posedge clk);
        `check_eq({ea, eb, ec}, 3'b110)
        `check_eq(per_a, 2)
        ctrl_pin <= 1;
        set_misc(32'h0020_0003);
        ctrl_pin <= 0;
        repeat (4) @(posedge clk);
        `check_eq({osc_en, ea, ec}, 3'b000)
        ctrl_pin <= 1;
        // just out of shutdown: outputs back, no synthesizer locked yet
        bus(0, 6'h20, 0, 32'h0000_00f8);
        repeat (60) @(posedge clk);
        `check_eq(osc_en, 1'b1)
        `check_eq(per_a, 2)
        bus(0, 6'h20, 0, 32'h0000_00ff);
        // synth one feeds a and b, b inverted; synth three feeds c
        bus(1, 6'h10, 32'h0001_0101, 0);
        bus(1, 6'h14, 32'h0005_0101, 0);
        bus(1, 6'h18, 32'h0003_0001, 0);
        set_misc(32'h0020_0000);
        `check_eq(per_a, 8)
        `check_eq(per_c, 4)
        `check_eq(ca ^ cb, 1'b1)
        ctrl_pin <= 0;
        repeat (40) @(posedge clk);
        `check_eq(per_a, 4)
        // suspend synth one together with both outputs it feeds
        set_misc(32'h0020_0311);
        `check_eq({ea, eb, ec}, 3'b001)
        bus(0, 6'h20, 0, 32'h0000_008e);
        set_misc(32'h0520_0000);
        `check_eq({byp, fb_oe, cap}, 8'h80)
        `check_eq(drv, 2'h1)
        end_sim;
    end
endmodule : three_synth_clock_router_bench
